// ### verilog/rom_select_pkg.sv
// Constants, register layout and state type for the boot ROM select decoder.
// Assumes a 26-bit linear CPU address and an 8-bit index/data register port.
package rom_select_pkg;
   // ==========================================================
   // Register port
   localparam logic [7:0] INDEX_PORT = 8'h22;
   localparam logic [7:0] DATA_PORT = 8'h23;
   localparam logic [7:0] IDX_SHADOW_CTRL = 8'h21;
   localparam logic [7:0] IDX_SEG_ATTR = 8'h22;
   localparam logic [7:0] IDX_CFG_A = 8'h23;
   localparam logic [7:0] RESET_SHADOW_CTRL = 8'h00;
   localparam logic [7:0] RESET_SEG_ATTR = 8'h00;
   localparam logic [7:0] RESET_INDEX = 8'h00;
   localparam logic [2:0] RESET_CFG_A = 3'h0;
   // ==========================================================
   // Field positions
   localparam int SH_BOOT_CACHE = 7;
   localparam int SH_TO_SOCKET = 6;
   localparam int SH_SHADOW = 5;
   localparam int SH_F_OFF = 4;
   localparam int SH_TOP_OFF = 3;
   localparam int SH_C_ON = 2;
   localparam int ATTR_CACHE_C = 7;
   localparam int ATTR_WP_C = 3;
   localparam int CFG_EARLY = 5;
   localparam int CFG_FAST = 4;
   localparam int CFG_WS_SEL = 3;
   localparam int CFG_WIDTH_LO = 1;
   localparam int CFG_STORE_LO = 3;
   // ==========================================================
   // Address map
   localparam int ADDR_W = 26;
   localparam int SEG_LO = 16;
   localparam int NUM_SEG = 4;
   localparam int SEG_F = 3;
   localparam logic [9:0] SEG_TAG_C = 10'h00c;
   localparam logic [9:0] SEG_TAG_TOP = 10'h3ff;
   localparam logic [1:0] WIDTH_32 = 2'h3;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int FAST_MAX_MHZ = 33;
   localparam int ISA_MIN_NS = 120;
   localparam int ISA_MIN_CYCLES = (ISA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAIT_W = 3;
   typedef enum logic [1:0] {ST_IDLE, ST_FAST, ST_ISA, ST_DONE} access_state_t;
endpackage

// ### verilog/segment_attr.sv
// Decode and attribute gating for one legacy 64 KB segment.
// Assumes the caller supplies the upper address field and the segment's control bits.
`timescale 1ns/100ps
module segment_attr #(
   parameter logic [9:0] SEG_TAG = 10'h00c
) (
   // Address
   input wire logic [9:0] segField,
   // Controls
   input wire logic decodeOn,
   input wire logic cacheBit,
   input wire logic protectBit,
   // Results
   output logic hit,
   output logic active,
   output logic cacheable,
   output logic protect
);
   // ==========================================================
   // Attributes only count while the segment is decoded
   always_comb begin
      hit = (segField == SEG_TAG);
      active = hit && decodeOn;
      cacheable = active && cacheBit;
      protect = active && protectBit;
   end
endmodule

// ### verilog/wait_counter.sv
// Down counter for wait states of one ROM access.
// Assumes load is a single-cycle strobe from the access state machine.
`timescale 1ns/100ps
module wait_counter #(
   parameter int W = 3
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Control
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   // Status
   output logic expired
);
   logic [W-1:0] count_r;

   // ==========================================================
   // Counter
   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= '0;
      end else if (load) begin
         count_r <= loadValue;
      end else if (count_r != '0) begin
         count_r <= count_r - 1'b1;
      end
   end

   assign expired = (count_r == '0);
endmodule

// ### verilog/rom_select_decode_shadow.sv
// Boot ROM select decode, shadowing, segment attributes and access timing.
// Assumes one CPU request at a time and an index/data I/O port from the core.
`timescale 1ns/100ps
module rom_select_decode_shadow (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Register port
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] ioAddr,
   input wire logic [7:0] ioWrData,
   output logic [7:0] ioRdData_r,
   // Straps and core status
   input wire logic [1:0] bootRomWidthStrap,
   input wire logic coreSoftReset,
   input wire logic systemManagementState,
   // CPU memory request
   input wire logic memReq,
   input wire logic [rom_select_pkg::ADDR_W-1:0] memAddr,
   input wire logic memWrite,
   input wire logic memBurst,
   input wire logic memBurstBeat,
   input wire logic secondRomSpace,
   input wire logic memoryMappingWindowHit,
   input wire logic [2:0] nonBurstWaitCount,
   input wire logic [1:0] burstWaitCount,
   input wire logic romCommand,
   input wire logic ioChannelReady,
   output logic memDone_r,
   // Routing and attributes
   output logic bootRomSelect_r,
   output logic secondRomSelect_r,
   output logic cardSocketSelect_r,
   output logic dramSelect_r,
   output logic isaSelect_r,
   output logic mappingWindowSelect_r,
   output logic cacheable_r,
   output logic writeInhibit_r,
   output logic fastMode_r,
   output logic burstTiming_r
);
   logic [7:0] index_r;
   logic [7:0] shadowCtrl_r;
   logic [7:0] segAttr_r;
   logic [2:0] cfgA_r;
   logic [1:0] widthStrap_r;
   rom_select_pkg::access_state_t state_r;
   rom_select_pkg::access_state_t state_nxt;
   logic [9:0] segField;
   logic [rom_select_pkg::NUM_SEG-1:0] segOn, segHit, segActive, segCache, segProt;
   logic topHit, topRom, topCache, anySegHit, anySegActive;
   logic romDecode, dramDecode, isaDecode, mmsDecode;
   logic cacheDecode, protectDecode, fastDecode, burstDecode, externalCycle;
   logic [rom_select_pkg::WAIT_W-1:0] waitLoad;
   logic accept, counterLoad, counterExpired, dataWrite;
   logic romDecodeHeld_r;

   // ==========================================================
   // Register port
   assign dataWrite = ioWrite && (ioAddr == rom_select_pkg::DATA_PORT);

   always_ff @(posedge clk) begin
      if (rst) begin
         index_r <= rom_select_pkg::RESET_INDEX;
      end else if (ioWrite && ioAddr == rom_select_pkg::INDEX_PORT) begin
         index_r <= ioWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shadowCtrl_r <= rom_select_pkg::RESET_SHADOW_CTRL;
      end else begin
         if (dataWrite && index_r == rom_select_pkg::IDX_SHADOW_CTRL) begin
            shadowCtrl_r <= ioWrData;
         end
         // Hardware clear wins over a write in the same cycle
         if (coreSoftReset) begin
            shadowCtrl_r[rom_select_pkg::SH_TOP_OFF] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         segAttr_r <= rom_select_pkg::RESET_SEG_ATTR;
         cfgA_r <= rom_select_pkg::RESET_CFG_A;
      end else if (dataWrite && index_r == rom_select_pkg::IDX_SEG_ATTR) begin
         segAttr_r <= ioWrData;
      end else if (dataWrite && index_r == rom_select_pkg::IDX_CFG_A) begin
         cfgA_r <= ioWrData[rom_select_pkg::CFG_EARLY:rom_select_pkg::CFG_STORE_LO];
      end
   end

   // Strap is sampled on every clock while reset is held, so its last value stays
   always_ff @(posedge clk) begin
      if (rst) begin
         widthStrap_r <= bootRomWidthStrap;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ioRdData_r <= 8'h00;
      end else if (ioRead && ioAddr == rom_select_pkg::INDEX_PORT) begin
         ioRdData_r <= index_r;
      end else if (ioRead && ioAddr == rom_select_pkg::DATA_PORT) begin
         case (index_r)
            rom_select_pkg::IDX_SHADOW_CTRL: ioRdData_r <= shadowCtrl_r;
            rom_select_pkg::IDX_SEG_ATTR: ioRdData_r <= segAttr_r;
            rom_select_pkg::IDX_CFG_A: ioRdData_r <= {2'h0, cfgA_r, widthStrap_r, 1'b0};
            default: ioRdData_r <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Segment decode
   assign segField = memAddr[rom_select_pkg::ADDR_W-1:rom_select_pkg::SEG_LO];
   // F uses an inverted disable bit; C, D and E use enables; bit n is segment n from C up
   assign segOn = {~shadowCtrl_r[rom_select_pkg::SH_F_OFF],
                   shadowCtrl_r[rom_select_pkg::SH_C_ON-2],
                   shadowCtrl_r[rom_select_pkg::SH_C_ON-1],
                   shadowCtrl_r[rom_select_pkg::SH_C_ON]};

   genvar gi;
   generate
      for (gi = 0; gi < rom_select_pkg::NUM_SEG; gi++) begin : g_seg
         segment_attr #(
            .SEG_TAG(rom_select_pkg::SEG_TAG_C + 10'(gi))
         ) u_seg (
            .segField(segField),
            .decodeOn(segOn[gi]),
            .cacheBit(segAttr_r[rom_select_pkg::ATTR_CACHE_C-gi]),
            .protectBit(segAttr_r[rom_select_pkg::ATTR_WP_C-gi]),
            .hit(segHit[gi]),
            .active(segActive[gi]),
            .cacheable(segCache[gi]),
            .protect(segProt[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Routing decision
   always_comb begin
      topHit = (segField == rom_select_pkg::SEG_TAG_TOP);
      topRom = topHit && !shadowCtrl_r[rom_select_pkg::SH_TOP_OFF];
      topCache = topRom && shadowCtrl_r[rom_select_pkg::SH_BOOT_CACHE];
      anySegHit = |segHit;
      anySegActive = |segActive;
      if (segHit[rom_select_pkg::SEG_F] && systemManagementState) begin
         romDecode = 1'b0;
         dramDecode = 1'b1;
      end else begin
         romDecode = topRom ||
                     (anySegActive && !shadowCtrl_r[rom_select_pkg::SH_SHADOW]);
         dramDecode = (anySegActive && shadowCtrl_r[rom_select_pkg::SH_SHADOW]) ||
                      (topHit && !topRom && !memoryMappingWindowHit);
      end
      // Undecoded segments fall to a mapping window if one claims them, else ISA
      mmsDecode = memoryMappingWindowHit && !romDecode && !dramDecode;
      isaDecode = anySegHit && !romDecode && !dramDecode && !memoryMappingWindowHit;
      cacheDecode = topCache || (|segCache);
      protectDecode = memWrite && (|segProt);
      fastDecode = cfgA_r[rom_select_pkg::CFG_FAST-rom_select_pkg::CFG_STORE_LO] ||
                   (widthStrap_r == rom_select_pkg::WIDTH_32);
      burstDecode = cfgA_r[rom_select_pkg::CFG_WS_SEL-rom_select_pkg::CFG_STORE_LO] &&
                    memBurst && cacheDecode && fastDecode;
      externalCycle = romDecode || (secondRomSpace && !romDecode);
      if (!fastDecode) begin
         waitLoad = rom_select_pkg::WAIT_W'(rom_select_pkg::ISA_MIN_CYCLES);
      end else if (burstDecode && memBurstBeat) begin
         waitLoad = {1'b0, burstWaitCount};
      end else begin
         waitLoad = nonBurstWaitCount;
      end
   end

   // ==========================================================
   // Access sequencing
   assign accept = memReq && (state_r == rom_select_pkg::ST_IDLE);
   assign counterLoad = accept && externalCycle;

   wait_counter #(
      .W(rom_select_pkg::WAIT_W)
   ) u_wait (
      .clk(clk),
      .rst(rst),
      .load(counterLoad),
      .loadValue(waitLoad),
      .expired(counterExpired)
   );

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rom_select_pkg::ST_IDLE: begin
            if (accept && externalCycle && fastDecode) begin
               state_nxt = rom_select_pkg::ST_FAST;
            end else if (accept && externalCycle) begin
               state_nxt = rom_select_pkg::ST_ISA;
            end else if (accept) begin
               state_nxt = rom_select_pkg::ST_DONE;
            end
         end
         rom_select_pkg::ST_FAST: begin
            if (counterExpired) begin
               state_nxt = rom_select_pkg::ST_DONE;
            end
         end
         rom_select_pkg::ST_ISA: begin
            if (counterExpired && ioChannelReady) begin
               state_nxt = rom_select_pkg::ST_DONE;
            end
         end
         rom_select_pkg::ST_DONE: state_nxt = rom_select_pkg::ST_IDLE;
         default: state_nxt = rom_select_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= rom_select_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Protected writes finish like any other; only the write strobe is held off
   always_ff @(posedge clk) begin
      if (rst) begin
         memDone_r <= 1'b0;
      end else begin
         memDone_r <= (state_nxt == rom_select_pkg::ST_DONE);
      end
   end

   // ==========================================================
   // Routing and attribute outputs, held for the whole access
   always_ff @(posedge clk) begin
      if (rst || state_nxt == rom_select_pkg::ST_IDLE) begin
         dramSelect_r <= 1'b0;
         isaSelect_r <= 1'b0;
         mappingWindowSelect_r <= 1'b0;
         cardSocketSelect_r <= 1'b0;
         secondRomSelect_r <= 1'b0;
         cacheable_r <= 1'b0;
         writeInhibit_r <= 1'b0;
         fastMode_r <= 1'b0;
         burstTiming_r <= 1'b0;
      end else if (accept) begin
         dramSelect_r <= dramDecode;
         isaSelect_r <= isaDecode;
         mappingWindowSelect_r <= mmsDecode;
         cardSocketSelect_r <= secondRomSpace && !romDecode &&
                               shadowCtrl_r[rom_select_pkg::SH_TO_SOCKET];
         secondRomSelect_r <= secondRomSpace && !romDecode &&
                              !shadowCtrl_r[rom_select_pkg::SH_TO_SOCKET];
         cacheable_r <= cacheDecode;
         writeInhibit_r <= protectDecode;
         fastMode_r <= fastDecode;
         burstTiming_r <= burstDecode;
      end
   end

   // Early select follows raw decode; otherwise it waits one edge and, slow, the command
   always_ff @(posedge clk) begin
      if (rst || state_nxt == rom_select_pkg::ST_IDLE) begin
         bootRomSelect_r <= 1'b0;
      end else if (accept) begin
         bootRomSelect_r <= romDecode &&
                            cfgA_r[rom_select_pkg::CFG_EARLY-rom_select_pkg::CFG_STORE_LO];
      end else if (romDecodeHeld_r) begin
         bootRomSelect_r <= cfgA_r[rom_select_pkg::CFG_EARLY-rom_select_pkg::CFG_STORE_LO] ||
                            fastMode_r || romCommand;
      end
   end

   always_ff @(posedge clk) begin
      if (rst || state_nxt == rom_select_pkg::ST_IDLE) begin
         romDecodeHeld_r <= 1'b0;
      end else if (accept) begin
         romDecodeHeld_r <= romDecode;
      end
   end

   // ==========================================================
   // Checks
   logic topOff, shadowOn, earlyOn;
   assign topOff = shadowCtrl_r[rom_select_pkg::SH_TOP_OFF];
   assign shadowOn = shadowCtrl_r[rom_select_pkg::SH_SHADOW];
   assign earlyOn = cfgA_r[rom_select_pkg::CFG_EARLY-rom_select_pkg::CFG_STORE_LO];

   property p_top_cache;
      @(posedge clk) disable iff (rst)
      accept && topHit && !topOff |=> cacheable_r == $past(shadowCtrl_r[7]);
   endproperty
   a_top_cache: assert property (p_top_cache) else $error("top cache wrong");

   property p_socket;
      @(posedge clk) disable iff (rst)
      accept && secondRomSpace && !romDecode && shadowCtrl_r[6]
      |=> cardSocketSelect_r && !secondRomSelect_r;
   endproperty
   a_socket: assert property (p_socket) else $error("second ROM not redirected");

   property p_shadow;
      @(posedge clk) disable iff (rst)
      accept && anySegActive && shadowOn && !topHit |=> dramSelect_r && !bootRomSelect_r;
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not to DRAM");

   property p_smm;
      @(posedge clk) disable iff (rst)
      accept && segHit[3] && systemManagementState |=> dramSelect_r [*1] ##1 !bootRomSelect_r;
   endproperty
   a_smm: assert property (p_smm) else $error("SYSTEM_MANAGEMENT_STATE F access not DRAM");

   property p_top_rom;
      @(posedge clk) disable iff (rst)
      accept && topHit && !topOff && earlyOn |=> bootRomSelect_r && !dramSelect_r;
   endproperty
   a_top_rom: assert property (p_top_rom) else $error("top region lost ROM");

   property p_top_off;
      @(posedge clk) disable iff (rst)
      accept && topHit && topOff |=> !bootRomSelect_r [*2];
   endproperty
   a_top_off: assert property (p_top_off) else $error("ROM select in disabled top");

   property p_soft_reset;
      @(posedge clk) disable iff (rst)
      coreSoftReset |=> !topOff;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset kept top off");

   property p_ignore_attr;
      @(posedge clk) disable iff (rst)
      accept && !anySegActive && !topHit |=> !writeInhibit_r && !cacheable_r;
   endproperty
   a_ignore_attr: assert property (p_ignore_attr) else $error("attribute on idle seg");

   property p_late_select;
      @(posedge clk) disable iff (rst)
      accept && romDecode && !earlyOn && fastDecode |=> !bootRomSelect_r ##1 bootRomSelect_r;
   endproperty
   a_late_select: assert property (p_late_select) else $error("select timing wrong");

   property p_strap_fast;
      @(posedge clk) disable iff (rst)
      accept && widthStrap_r == 2'h3 |=> fastMode_r;
   endproperty
   a_strap_fast: assert property (p_strap_fast) else $error("32-bit not fast");

   property p_isa_wait;
      @(posedge clk) disable iff (rst)
      state_r == rom_select_pkg::ST_ISA && !ioChannelReady |=> !memDone_r;
   endproperty
   a_isa_wait: assert property (p_isa_wait) else $error("ISA cycle ended early");

   property p_burst;
      @(posedge clk) disable iff (rst)
      burstTiming_r |-> fastMode_r && cacheable_r;
   endproperty
   a_burst: assert property (p_burst) else $error("burst without fast cache");

   property p_fast_zero;
      @(posedge clk) disable iff (rst)
      accept && externalCycle && fastDecode && waitLoad == 3'h0 |=> ##1 memDone_r;
   endproperty
   a_fast_zero: assert property (p_fast_zero) else $error("fast access too long");

   c_boot: cover property (@(posedge clk) accept && romDecode);
   c_shadow: cover property (@(posedge clk) accept && dramDecode && anySegActive);
   c_isa_wait: cover property (@(posedge clk) state_r == rom_select_pkg::ST_ISA && !ioChannelReady);
   c_burst: cover property (@(posedge clk) burstTiming_r && memDone_r);
endmodule

// ### tb/rom_device_model.sv
// Behavioural boot ROM device that answers ROM and ISA cycles with channel ready.
// Assumes the selects are registered levels from the decoder under test.
`timescale 1ns/100ps
module rom_device_model (
   // Clock
   input wire logic clk,
   // Selects
   input wire logic bootRomSelect,
   input wire logic isaSelect,
   // Settings
   input wire logic [3:0] slowCycles,
   // Answer
   output logic ioChannelReady
);
   logic [3:0] age_r;
   // ==========================================================
   // Ready line has a pull-up, so it reads high while no cycle runs
   always_ff @(posedge clk) begin
      if (!(bootRomSelect || isaSelect)) age_r <= 4'h0;
      else if (age_r != 4'hf) age_r <= age_r + 4'h1;
   end
   assign ioChannelReady = !(bootRomSelect || isaSelect) || (age_r >= slowCycles);
endmodule

// ### tb/rom_select_decode_shadow_bench.sv
// Self-checking bench for the boot ROM select decoder.
// Assumes the behavioural ROM device model on the channel ready line.
`timescale 1ns/100ps
module rom_select_decode_shadow_bench;
   logic clk, rst, ioWrite, ioRead, coreSoftReset, systemManagementState, memReq;
   logic memWrite, memBurst, memBurstBeat, secondRomSpace, memoryMappingWindowHit;
   logic romCommand, ioChannelReady, memDone_r, rdLate, on, sh, wr, bt;
   logic bootRomSelect_r, secondRomSelect_r, cardSocketSelect_r, dramSelect_r, isaSelect_r;
   logic mappingWindowSelect_r, cacheable_r, writeInhibit_r, fastMode_r, burstTiming_r;
   logic [7:0] ioAddr, ioWrData, ioRdData_r, ctl;
   logic [1:0] bootRomWidthStrap, burstWaitCount;
   logic [2:0] nonBurstWaitCount;
   logic [3:0] slowCycles;
   logic [rom_select_pkg::ADDR_W-1:0] memAddr;
   logic [9:0] routeVec;
   logic [5:0] reqAge;
   logic [15:0] mE, memQ[$];
   logic [7:0] rdQ[$];
   logic [31:0] seed;
   int bad_count, cmp_count;
   assign routeVec = {bootRomSelect_r, secondRomSelect_r, cardSocketSelect_r, dramSelect_r,
      isaSelect_r, mappingWindowSelect_r, cacheable_r, writeInhibit_r, fastMode_r, burstTiming_r};
   rom_select_decode_shadow u_rom_select_decode_shadow (.clk, .rst, .ioWrite, .ioRead, .ioAddr,
      .ioWrData, .ioRdData_r, .bootRomWidthStrap, .coreSoftReset, .systemManagementState,
      .memReq, .memAddr, .memWrite, .memBurst, .memBurstBeat, .secondRomSpace,
      .memoryMappingWindowHit, .nonBurstWaitCount, .burstWaitCount, .romCommand,
      .ioChannelReady, .memDone_r, .bootRomSelect_r, .secondRomSelect_r, .cardSocketSelect_r,
      .dramSelect_r, .isaSelect_r, .mappingWindowSelect_r, .cacheable_r, .writeInhibit_r,
      .fastMode_r, .burstTiming_r);
   rom_device_model u_rom_device_model (.clk, .bootRomSelect(bootRomSelect_r),
      .isaSelect(isaSelect_r), .slowCycles, .ioChannelReady);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ==========================================================
   // Helpers
   function automatic logic [31:0] nextRand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic doReset(input logic [1:0] strap);
      @(negedge clk) {rst, bootRomWidthStrap} = {1'b1, strap};
      repeat (5) @(negedge clk);
      rst = 1'b0;
   endtask
   task automatic regWr(input logic [7:0] idx, input logic [7:0] val);
      @(negedge clk) {ioWrite, ioAddr, ioWrData} = {1'b1, 8'h22, idx};
      @(negedge clk) {ioAddr, ioWrData} = {8'h23, val};
      @(negedge clk) ioWrite = 1'b0;
   endtask
   task automatic regRd(input logic [7:0] idx, input logic [7:0] val);
      @(negedge clk) {ioWrite, ioAddr, ioWrData} = {1'b1, 8'h22, idx};
      @(negedge clk) {ioWrite, ioRead, ioAddr} = {1'b0, 1'b1, 8'h23};
      rdQ.push_back(val);
      @(negedge clk) ioRead = 1'b0;
      @(negedge clk);
   endtask
   // Latency 6'h3f marks a cycle count that the checker ignores
   task automatic memAcc(input logic [25:0] a, input logic w, input logic [15:0] ev);
      int n;
      @(negedge clk) {memReq, memAddr, memWrite} = {1'b1, a, w};
      memQ.push_back(ev);
      @(negedge clk) memReq = 1'b0;
      n = 0;
      while (memDone_r !== 1'b1 && n < 40) begin
         @(negedge clk) n++;
      end
      if (n == 40) check(16'h0000, 16'hffff);
      @(negedge clk);
   endtask
   // ==========================================================
   // Monitor: timing bits only mean something on boot ROM cycles
   always @(posedge clk) begin
      rdLate <= ioRead;
      reqAge <= memReq ? 6'h01 : reqAge + 6'h01;
   end
   always @(negedge clk) begin
      if (rdLate === 1'b1) check({8'h00, rdQ.pop_front()}, {8'h00, ioRdData_r});
      if (memDone_r === 1'b1) begin
         mE = memQ.pop_front();
         check(mE, {(mE[15:10] == 6'h3f) ? 6'h3f : reqAge, routeVec[9:2],
            routeVec[1:0] & {2{mE[9]}}});
      end
   end
   initial begin
      #400000;
      bad_count++;
      test_done();
   end
   // ==========================================================
   // Main sequence
   initial begin
      {rst, ioWrite, ioRead, coreSoftReset, systemManagementState, memReq} = 6'h20;
      {memWrite, memBurst, memBurstBeat, secondRomSpace, memoryMappingWindowHit} = 5'h00;
      {romCommand, ioAddr, ioWrData, memAddr} = {1'b1, 16'h0000, 26'h000_0000};
      {nonBurstWaitCount, burstWaitCount, slowCycles, bootRomWidthStrap} = 11'h003;
      seed = 32'h85c0_7365;
      doReset(2'h3);
      regRd(8'h21, 8'h00);
      regRd(8'h22, 8'h00);
      regRd(8'h23, 8'h06);
      regWr(8'h30, 8'h5a);
      regRd(8'h30, 8'h00);
      seed = nextRand(seed);
      regWr(8'h22, seed[7:0]);
      regRd(8'h22, seed[7:0]);
      regWr(8'h23, 8'hff);
      regRd(8'h23, 8'h3e);
      regWr(8'h23, 8'h00);
      $display("test registers done");
      for (int s = 0; s < 4; s++) begin
         for (int m = 0; m < 3; m++) begin
            {on, sh, ctl} = {m != 0, m == 2, 8'h00};
            ctl[5] = sh;
            if (s == 3) ctl[4] = !on;
            else ctl[2 - s] = on;
            regWr(8'h21, ctl);
            seed = nextRand(seed);
            wr = seed[16];
            // Protected segments are never cached: writes see protection, reads caching
            regWr(8'h22, wr ? 8'h0f : 8'hf0);
            memAcc({6'h00, 4'hc + 4'(s), seed[15:0]}, wr, {(on && !sh) ? 6'h02 : 6'h01,
               on && !sh, 2'h0, on && sh, !on, 1'b0, on && !wr, on && wr, on && !sh,
               1'b0});
         end
      end
      $display("test segments done");
      for (int m = 0; m < 4; m++) begin
         memoryMappingWindowHit = (m == 3);
         regWr(8'h21, {m == 1, 2'h1, 1'b0, m[1], 3'h0});
         seed = nextRand(seed);
         memAcc({10'h3ff, seed[15:0]}, 1'b0, {m[1] ? 6'h01 : 6'h02, !m[1], 2'h0, m == 2,
            1'b0, m == 3, m == 1, 1'b0, !m[1], 1'b0});
      end
      {memoryMappingWindowHit, secondRomSpace} = 2'h1;
      for (int m = 0; m < 2; m++) begin
         regWr(8'h21, {1'b0, m[0], 6'h00});
         memAcc(26'h010_0000, 1'b0, {6'h3f, 1'b0, !m[0], m[0], 7'h00});
      end
      secondRomSpace = 1'b0;
      regWr(8'h22, 8'h00);
      regWr(8'h21, 8'h10);
      for (int m = 0; m < 2; m++) begin
         systemManagementState = !m[0];
         memAcc(26'h00f_1234, 1'b0, {6'h01, 3'h0, !m[0], m[0], 5'h00});
      end
      regWr(8'h21, 8'h2c);
      @(negedge clk) coreSoftReset = 1'b1;
      @(negedge clk) coreSoftReset = 1'b0;
      regRd(8'h21, 8'h24);
      $display("test top, second, management and soft reset done");
      regWr(8'h21, 8'h04);
      {nonBurstWaitCount, burstWaitCount, memBurst, memBurstBeat} = 7'h37;
      for (int k = 0; k < 3; k++) begin
         regWr(8'h22, (k == 1) ? 8'h00 : 8'h80);
         regWr(8'h23, (k == 2) ? 8'h00 : 8'h08);
         bt = (k == 0);
         memAcc(26'h00c_0010, 1'b0, {bt ? 6'h03 : 6'h05, 6'h20, k != 1, 2'h1, bt});
      end
      {nonBurstWaitCount, burstWaitCount, memBurst, memBurstBeat} = 7'h00;
      $display("test burst done");
      doReset(2'h2);
      regRd(8'h23, 8'h04);
      slowCycles = 4'h6;
      regWr(8'h21, 8'h04);
      for (int k = 0; k < 3; k++) begin
         // Early select is on for k 0 and 1; k 2 runs slow with early off and the command held low
         regWr(8'h23, (k == 2) ? 8'h00 : (k == 1) ? 8'h30 : 8'h20);
         romCommand = (k != 2);
         memAcc(26'h00c_0100, 1'b0, {(k == 1) ? 6'h02 : 6'h3f, k != 2, 7'h00, k == 1,
            1'b0});
      end
      $display("test strap and speed done");
      test_done();
   end
endmodule
